// ===== bench/pci_pins_model.sv
// pin levels of ports B, C and E as the outside world drives them
`timescale 1ns/10ps
`default_nettype none
module pci_pins_model (
	input wire logic pclk,
	output var pci_pkg::pci_pins_t pins
);
	import pci_pkg::*;
	initial pins = '0;
	// levels move only after an edge and then hold, so no change is too short to see
	task automatic drive(input pci_pins_t v);
		@(posedge pclk);
		pins <= v;
	endtask
endmodule
`default_nettype wire

// ===== bench/pci_top_asserts.sv
// concurrent checks on the ports of the pin-change interrupt block
`timescale 1ns/10ps
`default_nettype none
module pci_top_asserts #(
	parameter int NPINS = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire pci_pkg::pci_apb_req_t apb_req,
	input wire pci_pkg::pci_apb_rsp_t apb_rsp,
	input wire pci_pkg::pci_pins_t pins,
	input wire logic change_int_master_enable,
	input wire logic change_summary_flag,
	input wire logic wake_req,
	input wire logic irq
);
	import pci_pkg::*;
	wire logic men = change_int_master_enable;
	wire logic sum = change_summary_flag;
	wire logic wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
	wire logic rd = apb_req.psel & apb_req.penable & !apb_req.pwrite;
	// port E registers sit at 0x24, 0x28 and 0x2C
	wire logic e_adr = (apb_req.paddr[11:4] == 8'h02) && (apb_req.paddr[3:2] != 2'h0);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_wake; wake_req == (men && sum); endproperty
	a_wake: assert property (p_wake) else $error("wake mismatch");
	property p_irq; irq |-> men; endproperty
	a_irq: assert property (p_irq) else $error("irq without enable");
	property p_men; $changed(men) |-> $past(wr); endproperty
	a_men: assert property (p_men) else $error("enable moved alone");
	property p_fall; $fell(sum) |-> $past(wr); endproperty
	a_fall: assert property (p_fall) else $error("summary cleared alone");
	// a flag appears three edges after the pin moves
	property p_rise; $rose(sum) |-> $past(wr) || ($past(pins, 4) != $past(pins, 3)); endproperty
	a_rise: assert property (p_rise) else $error("summary set alone");
	property p_rst; !$past(presetn) |-> !(sum || men || irq || wake_req); endproperty
	a_rst: assert property (p_rst) else $error("outputs not clear");
	property p_e; rd && e_adr |-> (apb_rsp.prdata & ~32'h8) == 32'h0; endproperty
	a_e: assert property (p_e) else $error("port E bits");
	property p_hi; rd |-> apb_rsp.prdata[31:8] == 24'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper read bits");
endmodule
bind pci_top pci_top_asserts #(.NPINS(NPINS)) pci_top_asserts_inst (.pclk(pclk),
	.presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .pins(pins), .irq(irq),
	.change_int_master_enable(change_int_master_enable), .wake_req(wake_req),
	.change_summary_flag(change_summary_flag));
`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench of the pin-change interrupt block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import pci_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	pci_apb_req_t apb_req = '0;
	pci_apb_rsp_t apb_rsp;
	pci_pins_t pins;
	logic men, sum, wake, irq;
	logic [31:0] rd;
	int err_count = 0;
	int n_checks = 0;
	always #10 pclk = ~pclk;
	pci_top pci_top_inst (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.pins(pins), .change_int_master_enable(men), .change_summary_flag(sum),
		.wake_req(wake), .irq(irq));
	pci_pins_model pci_pins_model_inst (.pclk(pclk), .pins(pins));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		apb_req <= '{a, 1'b1, 1'b0, w, d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		apb_req <= '0;
		chk({31'h0, apb_rsp.pslverr}, 32'h0);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		chk(rd, e);
	endtask
	task automatic t_reset;
		// walks past the last register into unmapped space
		for (int a = 0; a <= 64; a += 4) begin
			rdchk(12'(a), 32'h0);
		end
		$display("t_reset done");
	endtask
	task automatic t_edges;
		logic [11:0] b;
		logic [31:0] m;
		pci_pins_t v;
		for (int p = 0; p < 3; p++) begin
			b = 12'h00C + 12'(12 * p);
			m = (p == 2) ? 32'h08 : 32'hFF;
			v = 24'hFF0000 >> (8 * p);
			apb(b, 1'b1, 32'hFFFFFFFF);
			rdchk(b, m);
			pci_pins_model_inst.drive(v);
			repeat (4) @(posedge pclk);
			rdchk(b + 12'h8, m);
			apb(b + 12'h8, 1'b1, 32'h0);
			rdchk(b + 12'h8, 32'h0);
			apb(b, 1'b1, 32'h0);
			apb(b + 12'h4, 1'b1, 32'hFF);
			pci_pins_model_inst.drive('0);
			repeat (4) @(posedge pclk);
			rdchk(b + 12'h8, m);
			apb(b + 12'h8, 1'b1, 32'h0);
			pci_pins_model_inst.drive(v);
			repeat (4) @(posedge pclk);
			rdchk(b + 12'h8, 32'h0);
			apb(b + 12'h4, 1'b1, 32'h0);
		end
		$display("t_edges done");
	endtask
	task automatic t_irq;
		apb(12'h034, 1'b1, 32'h3);
		apb(12'h030, 1'b1, 32'h1);
		apb(12'h038, 1'b1, 32'h1);
		apb(12'h00C, 1'b1, 32'h2);
		// the clearing write lands on the very edge that sets the flag
		pci_pins_model_inst.drive(24'h020000);
		apb(12'h014, 1'b1, 32'h0);
		rdchk(12'h014, 32'h2);
		chk({irq, wake}, 2'b11);
		rdchk(12'h034, 32'h3);
		apb(12'h030, 1'b1, 32'h0);
		@(negedge pclk);
		chk({28'h0, irq, wake, sum, men}, 32'h2);
		rdchk(12'h030, 32'h2);
		apb(12'h034, 1'b1, 32'h3);
		rdchk(12'h034, 32'h0);
		$display("t_irq done");
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_edges();
		t_irq();
		give_verdict();
	end
	// the whole run needs well under a thousand cycles
	initial begin
		#100000;
		err_count++;
		give_verdict();
	end
endmodule
`default_nettype wire

// ===== core/pci_defs.svh
// register offsets, field positions and reset values of the pin-change interrupt block
`ifndef PCI_DEFS_SVH
`define PCI_DEFS_SVH

`define PCI_OFF_A_RISE 12'h000
`define PCI_OFF_A_FALL 12'h004
`define PCI_OFF_A_FLAG 12'h008
`define PCI_OFF_B_RISE 12'h00C
`define PCI_OFF_B_FALL 12'h010
`define PCI_OFF_B_FLAG 12'h014
`define PCI_OFF_C_RISE 12'h018
`define PCI_OFF_C_FALL 12'h01C
`define PCI_OFF_C_FLAG 12'h020
`define PCI_OFF_E_RISE 12'h024
`define PCI_OFF_E_FALL 12'h028
`define PCI_OFF_E_FLAG 12'h02C
`define PCI_OFF_CTRL 12'h030
`define PCI_OFF_STAT 12'h034
`define PCI_OFF_MASK 12'h038

`define PCI_E_MASK 8'h08
`define PCI_RST_BYTE 8'h00
`define PCI_CTRL_MEN_BIT 0
`define PCI_STAT_SUM_BIT 0
`define PCI_STAT_WAKE_BIT 1
`define PCI_ADDR_W 12

`endif

// ===== core/pci_pkg.sv
// types shared by the pin-change interrupt block
package pci_pkg;
	typedef struct packed {
		logic [7:0] rise;
		logic [7:0] fall;
	} pci_edge_cfg_t;

	typedef struct packed {
		logic [7:0] port_b_pin;
		logic [7:0] port_c_pin;
		logic [7:0] port_e_pin;
	} pci_pins_t;

	typedef struct packed {
		logic [11:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} pci_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} pci_apb_rsp_t;
endpackage

// ===== core/pci_top.sv
// pin-change interrupt logic for ports B, C and E with an APB register slave
`timescale 1ns/10ps
`default_nettype none
`include "pci_defs.svh"

module pci_top #(
	parameter int NPINS = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire pci_pkg::pci_apb_req_t apb_req,
	output pci_pkg::pci_apb_rsp_t apb_rsp,
	input wire pci_pkg::pci_pins_t pins,
	output logic change_int_master_enable,
	output logic change_summary_flag,
	output logic wake_req,
	output logic irq
);
	import pci_pkg::*;

	// the lanes and offsets below are laid out for eight pins per port
	if (NPINS != 8) begin : g_bad_npins
		$error("pci_top serves eight pins per port only");
	end

	// ==========================================================
	// pin synchronisers and edge detectors
	localparam int NBITS = 3 * NPINS;
	logic [NBITS-1:0] pin_meta_reg;
	logic [NBITS-1:0] pin_sync_reg;
	logic [NBITS-1:0] pin_prev_reg;
	wire [NBITS-1:0] pin_raw;
	wire [NBITS-1:0] rise_seen;
	wire [NBITS-1:0] fall_seen;

	assign pin_raw = {pins.port_e_pin, pins.port_c_pin, pins.port_b_pin};

	// prev comes from the second stage; meta is never compared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
			pin_prev_reg <= '0;
		end else begin
			pin_meta_reg <= pin_raw;
			pin_sync_reg <= pin_meta_reg;
			pin_prev_reg <= pin_sync_reg;
		end
	end

	assign rise_seen = pin_sync_reg & ~pin_prev_reg;
	assign fall_seen = ~pin_sync_reg & pin_prev_reg;

	// ==========================================================
	// register decode
	wire [`PCI_ADDR_W-1:0] addr;
	wire wr_en;
	wire rd_access;
	assign addr = apb_req.paddr;
	assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
	assign rd_access = apb_req.psel & ~apb_req.pwrite;

	function automatic logic hit(input logic [`PCI_ADDR_W-1:0] a, input logic [`PCI_ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	// ==========================================================
	// enables and flags, one generate lane per port
	logic [7:0] rise_reg [4];
	logic [7:0] fall_reg [4];
	logic [7:0] flag_reg [4];
	wire [7:0] lane_mask [4];
	wire [`PCI_ADDR_W-1:0] off_rise [4];
	wire [`PCI_ADDR_W-1:0] off_fall [4];
	wire [`PCI_ADDR_W-1:0] off_flag [4];
	wire [7:0] lane_set [4];

	assign lane_mask[0] = 8'hFF;
	assign lane_mask[1] = 8'hFF;
	assign lane_mask[2] = 8'hFF;
	assign lane_mask[3] = `PCI_E_MASK;
	assign off_rise[0] = `PCI_OFF_A_RISE;
	assign off_rise[1] = `PCI_OFF_B_RISE;
	assign off_rise[2] = `PCI_OFF_C_RISE;
	assign off_rise[3] = `PCI_OFF_E_RISE;
	assign off_fall[0] = `PCI_OFF_A_FALL;
	assign off_fall[1] = `PCI_OFF_B_FALL;
	assign off_fall[2] = `PCI_OFF_C_FALL;
	assign off_fall[3] = `PCI_OFF_E_FALL;
	assign off_flag[0] = `PCI_OFF_A_FLAG;
	assign off_flag[1] = `PCI_OFF_B_FLAG;
	assign off_flag[2] = `PCI_OFF_C_FLAG;
	assign off_flag[3] = `PCI_OFF_E_FLAG;

	// port A has no pins here, so its flags are only ever set by software
	assign lane_set[0] = 8'h00;

	genvar gp;
	generate
		for (gp = 1; gp < 4; gp++) begin : g_set
			assign lane_set[gp] = ((rise_reg[gp] & rise_seen[(gp-1)*NPINS +: 8])
				| (fall_reg[gp] & fall_seen[(gp-1)*NPINS +: 8])) & lane_mask[gp];
		end
		for (gp = 0; gp < 4; gp++) begin : g_port
			wire wr_rise;
			wire wr_fall;
			wire wr_flag;
			wire [7:0] flag_next;
			assign wr_rise = wr_en & hit(addr, off_rise[gp]);
			assign wr_fall = wr_en & hit(addr, off_fall[gp]);
			assign wr_flag = wr_en & hit(addr, off_flag[gp]);
			// set wins over a concurrent software write
			assign flag_next = (wr_flag ? apb_req.pwdata[7:0] : flag_reg[gp])
				| lane_set[gp];

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					rise_reg[gp] <= `PCI_RST_BYTE;
					fall_reg[gp] <= `PCI_RST_BYTE;
					flag_reg[gp] <= `PCI_RST_BYTE;
				end else begin
					if (wr_rise) begin
						rise_reg[gp] <= apb_req.pwdata[7:0] & lane_mask[gp];
					end
					if (wr_fall) begin
						fall_reg[gp] <= apb_req.pwdata[7:0] & lane_mask[gp];
					end
					flag_reg[gp] <= flag_next & lane_mask[gp];
				end
			end
		end
	endgenerate

	// ==========================================================
	// control, sticky status and mask
	logic men_reg;
	logic [1:0] stat_reg;
	logic [1:0] mask_reg;
	wire any_flag;
	wire any_set;
	wire [1:0] stat_evt;
	wire wr_ctrl;
	wire wr_stat;
	wire wr_mask;

	assign any_flag = |{flag_reg[0], flag_reg[1], flag_reg[2], flag_reg[3]};
	assign any_set = |{lane_set[1], lane_set[2], lane_set[3]};
	assign stat_evt[`PCI_STAT_SUM_BIT] = any_set;
	assign stat_evt[`PCI_STAT_WAKE_BIT] = any_set & men_reg;
	assign wr_ctrl = wr_en & hit(addr, `PCI_OFF_CTRL);
	assign wr_stat = wr_en & hit(addr, `PCI_OFF_STAT);
	assign wr_mask = wr_en & hit(addr, `PCI_OFF_MASK);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			men_reg <= 1'b0;
			stat_reg <= 2'h0;
			mask_reg <= 2'h0;
		end else begin
			if (wr_ctrl) begin
				men_reg <= apb_req.pwdata[`PCI_CTRL_MEN_BIT];
			end
			if (wr_mask) begin
				mask_reg <= apb_req.pwdata[1:0];
			end
			// write one to clear; a new event in the same cycle wins
			stat_reg <= (stat_reg & ~(wr_stat ? apb_req.pwdata[1:0] : 2'h0)) | stat_evt;
		end
	end

	assign change_int_master_enable = men_reg;
	assign change_summary_flag = any_flag;
	// flag and summary already hold the edge when wake rises
	assign wake_req = men_reg & any_flag;
	assign irq = men_reg & (|(stat_reg & mask_reg));

	// ==========================================================
	// read mux; zero wait states, unmapped reads give zero with no error
	logic [31:0] rdata_reg;
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			if (hit(addr, off_rise[i])) begin
				rd_mux[7:0] = rise_reg[i];
			end
			if (hit(addr, off_fall[i])) begin
				rd_mux[7:0] = fall_reg[i];
			end
			if (hit(addr, off_flag[i])) begin
				rd_mux[7:0] = flag_reg[i];
			end
		end
		if (hit(addr, `PCI_OFF_CTRL)) begin
			rd_mux[0] = men_reg;
			rd_mux[1] = any_flag;
		end
		if (hit(addr, `PCI_OFF_STAT)) begin
			rd_mux[1:0] = stat_reg;
		end
		if (hit(addr, `PCI_OFF_MASK)) begin
			rd_mux[1:0] = mask_reg;
		end
	end

	// captured in setup so the data is stable throughout the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_reg <= 32'h0000_0000;
		end else if (rd_access & ~apb_req.penable) begin
			rdata_reg <= rd_mux;
		end
	end

	// one driver for the whole response word; zero wait states, never an error
	assign apb_rsp = '{prdata: rdata_reg, pready: 1'b1, pslverr: 1'b0};
endmodule

`default_nettype wire
